// ==== verilog/pseirq_map.vh ====
`ifndef PSEIRQ_MAP_VH
`define PSEIRQ_MAP_VH
// ********************************
// Register addresses
// ********************************
`define PSE_ADDR_DIP_CYC 8'h13
`define PSE_ADDR_DIP_LVL 8'h14
`define PSE_ADDR_INTERRUPT_ENABLE_PRIORITY_TWO 8'hA9
`define PSE_ADDR_ADC_GO 8'hD8
`define PSE_ADDR_BAT_ADC 8'hDF
`define PSE_ADDR_EVT_EN 8'hEC
`define PSE_ADDR_DELTA 8'hF3
`define PSE_ADDR_PERIPHERAL_CONFIG 8'hF4
`define PSE_ADDR_TRIG_SEL 8'hF5
`define PSE_ADDR_FLAGS 8'hF8
`define PSE_ADDR_BAT_TH 8'hFA
// ********************************
// Field positions
// ********************************
`define PSE_GLOBAL_EN_BIT 1
`define PSE_SRC_STATUS_BIT 6
`define PSE_EV_DIP 0
`define PSE_EV_COMP 1
`define PSE_EV_BAT 2
`define PSE_EV_ADC 3
`define PSE_EV_RESTORE 4
`define PSE_EV_SWITCH 5
// ********************************
// Timing
// ********************************
`define PSE_CLK_HZ 10000000
`define PSE_SWITCH_MS 30
`define PSE_RESTORE_MS 130
`define PSE_SWITCH_CYC (`PSE_SWITCH_MS * (`PSE_CLK_HZ / 1000))
`define PSE_RESTORE_CYC (`PSE_RESTORE_MS * (`PSE_CLK_HZ / 1000))
`define PSE_ADC_PERIOD 1000
`endif

// ==== verilog/pse_sync.v ====
`default_nettype none
// ********************************
// Two-stage level synchroniser
// ********************************
module pse_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire nrst,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule
`default_nettype wire

// ==== verilog/pse_irq.v ====
`include "pseirq_map.vh"
`default_nettype none
// Notes on behaviour
// - Interrupt off after reset; raised only once global enable bit set.
// - Per-event enable register selects events driving the one shared vector.
// - Flags latch until software clears them by writing the flag register.
// - Main-to-battery change sets switchover flag; interrupts if enabled.
// - Battery-to-main change sets restore flag; interrupts if enabled.
// - Flags set regardless of enables; cleared by writing zero.
// - Status bit shows source: one on main, zero on battery.
// - Supply-input change beyond delta threshold flags an ADC event.
// - Background conversions plus software start; ready sets ADC flag.
// - Battery below threshold or new battery reading sets battery flag.
// - Supply input below comparator threshold sets comparator flag.
// - Line below dip level for programmed cycles sets dip flag.
// - Low supply-input switchover happens about 30 ms after drop.
// - Return to main about 130 ms after restore conditions met.
// - Select 00: main-low only; 01: supply input also, restore needs both.
module pse_irq #(
  parameter SWITCH_CYC = `PSE_SWITCH_CYC,
  parameter RESTORE_CYC = `PSE_RESTORE_CYC,
  parameter ADC_PERIOD = `PSE_ADC_PERIOD
) (
  input wire clk,
  input wire nrst,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  input wire main_low,
  input wire supervisory_low,
  input wire [7:0] supervisory_sample,
  input wire [7:0] battery_sample,
  input wire line_cycle,
  input wire [7:0] line_level,
  output wire internal_supply,
  output wire power_event_irq
);
  // ********************************
  // Pin synchronisers
  // ********************************
  wire main_low_s;
  wire sup_low_s;
  wire cyc_s;
  pse_sync #(.W(3)) i_pse_sync (
    .clk(clk),
    .nrst(nrst),
    .d({main_low, supervisory_low, line_cycle}),
    .q({main_low_s, sup_low_s, cyc_s})
  );
  // Samples are treated as quasi-static words, taken on conversion strobes
  reg [7:0] dip_cycle_count_q;
  reg [7:0] dip_level_threshold_q;
  reg [7:0] iep2_q;
  reg [7:0] power_event_enable_q;
  reg [7:0] temp_supply_delta_q;
  reg [7:0] peripheral_config_q;
  reg [1:0] switchover_trigger_select_q;
  reg [7:0] power_event_flags_q;
  reg [7:0] battery_threshold_q;
  reg [7:0] battery_adc_value_q;
  reg [7:0] sup_last_q;
  reg on_main_q;
  reg [31:0] tmr_q;
  reg [31:0] adc_tmr_q;
  reg adc_go_q;
  reg [7:0] dip_cnt_q;
  reg cyc_d1_q;
  reg [2:0] st_q;
  localparam [2:0] ST_MAIN = 3'b001;
  localparam [2:0] ST_WAITB = 3'b010;
  localparam [2:0] ST_BAT = 3'b100;

  function sel;
    input [7:0] a;
    input [7:0] b;
    begin
      sel = (a == b);
    end
  endfunction

  wire wr_flags = sfr_wr && sel(sfr_addr, `PSE_ADDR_FLAGS);
  // ********************************
  // Source switching
  // ********************************
  wire use_sup = (switchover_trigger_select_q == 2'b01);
  wire go_bat_now = main_low_s;
  wire go_bat_slow = use_sup && sup_low_s;
  wire restore_ok = !main_low_s && !(use_sup && sup_low_s);
  reg ev_switch;
  reg ev_restore;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_MAIN;
      tmr_q <= 32'h00000000;
      on_main_q <= 1'b1;
      ev_switch <= 1'b0;
      ev_restore <= 1'b0;
    end else begin
      ev_switch <= 1'b0;
      ev_restore <= 1'b0;
      case (st_q)
        ST_MAIN: begin
          tmr_q <= 32'h00000000;
          if (go_bat_now) begin
            st_q <= ST_BAT;
            on_main_q <= 1'b0;
            ev_switch <= 1'b1;
          end else if (go_bat_slow) begin
            st_q <= ST_WAITB;
          end
        end
        ST_WAITB: begin
          tmr_q <= tmr_q + 32'h00000001;
          if (go_bat_now || tmr_q >= SWITCH_CYC - 1) begin
            st_q <= ST_BAT;
            on_main_q <= 1'b0;
            ev_switch <= 1'b1;
            tmr_q <= 32'h00000000;
          end else if (!go_bat_slow) begin
            st_q <= ST_MAIN;
          end
        end
        ST_BAT: begin
          // Any dropout of the restore conditions restarts the wait
          if (!restore_ok) begin
            tmr_q <= 32'h00000000;
          end else if (tmr_q >= RESTORE_CYC - 1) begin
            st_q <= ST_MAIN;
            on_main_q <= 1'b1;
            ev_restore <= 1'b1;
            tmr_q <= 32'h00000000;
          end else begin
            tmr_q <= tmr_q + 32'h00000001;
          end
        end
        default: begin
          st_q <= ST_MAIN;
          on_main_q <= 1'b1;
        end
      endcase
    end
  end
  assign internal_supply = on_main_q;
  // ********************************
  // Conversions and dip detection
  // ********************************
  wire adc_tick = (adc_tmr_q >= ADC_PERIOD - 1);
  wire adc_conv = adc_tick || adc_go_q;
  wire [7:0] sup_diff = (supervisory_sample > sup_last_q) ?
    supervisory_sample - sup_last_q : sup_last_q - supervisory_sample;
  wire ev_adc_delta = adc_conv && (sup_diff > temp_supply_delta_q);
  wire ev_bat = adc_conv || (battery_adc_value_q < battery_threshold_q);
  wire cyc_edge = cyc_s && !cyc_d1_q;
  wire dip_low = line_level < dip_level_threshold_q;
  wire ev_dip = cyc_edge && dip_low &&
    (dip_cnt_q + 8'h01 == dip_cycle_count_q);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      adc_tmr_q <= 32'h00000000;
      sup_last_q <= 8'h00;
      battery_adc_value_q <= 8'hFF;
      dip_cnt_q <= 8'h00;
      cyc_d1_q <= 1'b0;
    end else begin
      cyc_d1_q <= cyc_s;
      adc_tmr_q <= adc_conv ? 32'h00000000 : adc_tmr_q + 32'h00000001;
      if (adc_conv) begin
        sup_last_q <= supervisory_sample;
        battery_adc_value_q <= battery_sample;
      end
      if (cyc_edge) begin
        if (!dip_low)
          dip_cnt_q <= 8'h00;
        else if (dip_cnt_q != 8'hFF)
          dip_cnt_q <= dip_cnt_q + 8'h01;
      end
    end
  end
  // ********************************
  // Registers
  // ********************************
  wire [7:0] ev_set;
  assign ev_set[`PSE_EV_DIP] = ev_dip;
  assign ev_set[`PSE_EV_COMP] = sup_low_s;
  assign ev_set[`PSE_EV_BAT] = ev_bat;
  assign ev_set[`PSE_EV_ADC] = ev_adc_delta || adc_conv;
  assign ev_set[`PSE_EV_RESTORE] = ev_restore;
  assign ev_set[`PSE_EV_SWITCH] = ev_switch;
  assign ev_set[7:6] = 2'b00;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dip_cycle_count_q <= 8'h00;
      dip_level_threshold_q <= 8'h00;
      iep2_q <= 8'h00;
      power_event_enable_q <= 8'h00;
      temp_supply_delta_q <= 8'h00;
      peripheral_config_q <= 8'h00;
      switchover_trigger_select_q <= 2'b00;
      battery_threshold_q <= 8'h00;
      power_event_flags_q <= 8'h00;
      adc_go_q <= 1'b0;
    end else begin
      adc_go_q <= sfr_wr && sel(sfr_addr, `PSE_ADDR_ADC_GO);
      if (sfr_wr) begin
        if (sel(sfr_addr, `PSE_ADDR_DIP_CYC))
          dip_cycle_count_q <= sfr_wdata;
        if (sel(sfr_addr, `PSE_ADDR_DIP_LVL))
          dip_level_threshold_q <= sfr_wdata;
        if (sel(sfr_addr, `PSE_ADDR_INTERRUPT_ENABLE_PRIORITY_TWO))
          iep2_q <= sfr_wdata;
        if (sel(sfr_addr, `PSE_ADDR_EVT_EN))
          power_event_enable_q <= sfr_wdata;
        if (sel(sfr_addr, `PSE_ADDR_DELTA))
          temp_supply_delta_q <= sfr_wdata;
        if (sel(sfr_addr, `PSE_ADDR_PERIPHERAL_CONFIG))
          peripheral_config_q <= sfr_wdata;
        if (sel(sfr_addr, `PSE_ADDR_TRIG_SEL))
          switchover_trigger_select_q <= sfr_wdata[1:0];
        if (sel(sfr_addr, `PSE_ADDR_BAT_TH))
          battery_threshold_q <= sfr_wdata;
      end
      // Zero clears, one keeps; a new event wins over the clear
      power_event_flags_q <= ((wr_flags ? (power_event_flags_q & sfr_wdata)
        : power_event_flags_q) | ev_set);
    end
  end
  assign power_event_irq = iep2_q[`PSE_GLOBAL_EN_BIT] &&
    |(power_event_flags_q & power_event_enable_q);
  always @* begin
    sfr_rdata = 8'h00;
    if (sfr_rd) begin
      case (sfr_addr)
        `PSE_ADDR_DIP_CYC: sfr_rdata = dip_cycle_count_q;
        `PSE_ADDR_DIP_LVL: sfr_rdata = dip_level_threshold_q;
        `PSE_ADDR_INTERRUPT_ENABLE_PRIORITY_TWO: sfr_rdata = iep2_q;
        `PSE_ADDR_BAT_ADC: sfr_rdata = battery_adc_value_q;
        `PSE_ADDR_EVT_EN: sfr_rdata = power_event_enable_q;
        `PSE_ADDR_DELTA: sfr_rdata = temp_supply_delta_q;
        `PSE_ADDR_TRIG_SEL: sfr_rdata = {6'h00, switchover_trigger_select_q};
        `PSE_ADDR_FLAGS: sfr_rdata = power_event_flags_q;
        `PSE_ADDR_BAT_TH: sfr_rdata = battery_threshold_q;
        `PSE_ADDR_PERIPHERAL_CONFIG: begin
          sfr_rdata = peripheral_config_q;
          sfr_rdata[`PSE_SRC_STATUS_BIT] = on_main_q;
        end
        default: sfr_rdata = 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== test/pse_irq_props.sv ====
`default_nettype none
// ****
// Power event checker
// ****
module pse_irq_chk #(
  parameter SWITCH_CYC = 20,
  parameter RESTORE_CYC = 30
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic main_low,
  input wire logic supervisory_low,
  input wire logic internal_supply,
  input wire logic power_event_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ge_q;
  logic [7:0] en_q;
  logic [1:0] sel_q;
  int ml_q;
  int sv_q;
  int ok_q;
  wire ok = !main_low && !(sel_q == 2'h1 && supervisory_low);
  // Shadow the enables from bus writes, so no hierarchy is needed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ge_q <= 1'b0;
      en_q <= 8'h00;
      sel_q <= 2'h0;
      ml_q <= 0;
      sv_q <= 0;
      ok_q <= 0;
    end else begin
      if (sfr_wr && sfr_addr == 8'hA9) ge_q <= sfr_wdata[1];
      if (sfr_wr && sfr_addr == 8'hEC) en_q <= sfr_wdata;
      if (sfr_wr && sfr_addr == 8'hF5) sel_q <= sfr_wdata[1:0];
      ml_q <= main_low ? ml_q + 1 : 0;
      sv_q <= supervisory_low ? sv_q + 1 : 0;
      ok_q <= ok ? ok_q + 1 : 0;
    end
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_gate; power_event_irq |-> ge_q && en_q != 8'h00; endproperty
  a_gate: assert property (p_gate) else $error("irq without enable");
  property p_off; sfr_wr && sfr_addr == 8'hA9 && !sfr_wdata[1] |=>
    !power_event_irq; endproperty
  a_off: assert property (p_off) else $error("irq after disable");
  property p_src; sfr_rd && sfr_addr == 8'hF4 |->
    sfr_rdata[6] == internal_supply; endproperty
  a_src: assert property (p_src) else $error("source bit wrong");
  property p_main; $rose(main_low) && internal_supply && !sel_q[1] |->
    ##[1:4] !internal_supply; endproperty
  a_main: assert property (p_main) else $error("no switchover");
  property p_swirq; ge_q && en_q[5] && $fell(internal_supply) |->
    ##[0:2] power_event_irq; endproperty
  a_swirq: assert property (p_swirq) else $error("no switch irq");
  property p_rsirq; ge_q && en_q[4] && $rose(internal_supply) |->
    ##[0:2] power_event_irq; endproperty
  a_rsirq: assert property (p_rsirq) else $error("no restore irq");
  property p_rwait; $rose(internal_supply) |-> ok_q >= RESTORE_CYC;
  endproperty
  a_rwait: assert property (p_rwait) else $error("early restore");
  property p_swait; $fell(internal_supply) |->
    ml_q > 0 || sv_q >= SWITCH_CYC; endproperty
  a_swait: assert property (p_swait) else $error("early switch");
  property p_comp; (supervisory_low && ge_q && en_q[1]) [*5] |->
    power_event_irq; endproperty
  a_comp: assert property (p_comp) else $error("no comparator irq");
  c_sw: cover property ($fell(internal_supply));
  c_rs: cover property ($rose(internal_supply));
  c_irq: cover property ($rose(power_event_irq));
endmodule
bind pse_irq pse_irq_chk #(.SWITCH_CYC(SWITCH_CYC),
  .RESTORE_CYC(RESTORE_CYC)) i_pse_irq_chk (.clk(clk), .nrst(nrst),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .main_low(main_low),
  .supervisory_low(supervisory_low), .internal_supply(internal_supply),
  .power_event_irq(power_event_irq));
`default_nettype wire

// ==== test/pse_core_model.sv ====
`default_nettype none
// ****
// Core register bus model
// ****
module pse_core_model (
  input wire logic clk,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic sfr_wr,
  output logic sfr_rd,
  input wire logic [7:0] sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  end
  // Flags are handled by writing zero to their bits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  // Read data is combinational, so take it at the sampling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    d = sfr_rdata;
    @(negedge clk);
    sfr_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== test/power_supply_event_interrupt_test.sv ====
`default_nettype none
// ****
// Power event bench
// ****
module power_supply_event_interrupt_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, main_low, sup_low, line_cycle;
  logic [7:0] sup_smp, bat_smp, line_level, v;
  wire [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  wire sfr_wr, sfr_rd, int_sup, irq;
  int error_cnt = 0;
  int compares = 0;
  // Short counts keep the run brief; expectations follow them
  pse_irq #(.SWITCH_CYC(20), .RESTORE_CYC(30), .ADC_PERIOD(16)) i_pse_irq (
    .clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .main_low(main_low), .supervisory_low(sup_low),
    .supervisory_sample(sup_smp), .battery_sample(bat_smp),
    .line_cycle(line_cycle), .line_level(line_level),
    .internal_supply(int_sup), .power_event_irq(irq));
  pse_core_model i_pse_core_model (.clk(clk), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata));
  task automatic chk(string what, logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    i_pse_core_model.wr(a, d);
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] m, logic [7:0] e);
    i_pse_core_model.rd(a, v);
    chk($sformatf("reg %h", a), v & m, e);
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_reset;
    chk("irq", {7'h00, irq}, 8'h00);
    rdc(8'hA9, 8'hFF, 8'h00);
    rdc(8'hF4, 8'hFF, 8'h40);
    rdc(8'h00, 8'hFF, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_switch;
    wr(8'hA9, 8'h02);
    wr(8'hEC, 8'h20);
    main_low = 1'b1;
    cyc(6);
    chk("supply", {7'h00, int_sup}, 8'h00);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(8'hF8, 8'hDF);
    rdc(8'hF8, 8'h30, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    main_low = 1'b0;
    cyc(25);
    chk("supply", {7'h00, int_sup}, 8'h00);
    cyc(12);
    rdc(8'hF8, 8'h30, 8'h10);
    chk("irq", {7'h00, irq}, 8'h00);
    wr(8'hF8, 8'hFF);
    rdc(8'hF8, 8'h10, 8'h10);
    wr(8'hEC, 8'h10);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(8'hA9, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    wr(8'hF8, 8'h00);
    $display("switchover test done");
  endtask
  task automatic t_adc;
    bat_smp = 8'h5A;
    wr(8'hFA, 8'h40);
    wr(8'hF8, 8'h00);
    wr(8'hD8, 8'h01);
    cyc(20);
    rdc(8'hDF, 8'hFF, 8'h5A);
    rdc(8'hF8, 8'h0C, 8'h0C);
    wr(8'hEC, 8'h08);
    wr(8'hA9, 8'h02);
    chk("irq", {7'h00, irq}, 8'h01);
    $display("conversion test done");
  endtask
  task automatic t_comp;
    wr(8'hEC, 8'h12);
    wr(8'hF5, 8'h01);
    wr(8'hF8, 8'h00);
    sup_low = 1'b1;
    cyc(5);
    chk("irq", {7'h00, irq}, 8'h01);
    cyc(10);
    chk("supply", {7'h00, int_sup}, 8'h01);
    cyc(15);
    chk("supply", {7'h00, int_sup}, 8'h00);
    sup_low = 1'b0;
    cyc(40);
    chk("supply", {7'h00, int_sup}, 8'h01);
    wr(8'hF5, 8'h00);
    $display("comparator test done");
  endtask
  task automatic pulse(int n);
    repeat (n) begin
      line_cycle = 1'b1;
      cyc(3);
      line_cycle = 1'b0;
      cyc(3);
    end
  endtask
  task automatic t_dip;
    wr(8'h13, 8'h03);
    wr(8'h14, 8'h40);
    line_level = 8'h10;
    wr(8'hF8, 8'h00);
    pulse(2);
    rdc(8'hF8, 8'h01, 8'h00);
    pulse(1);
    rdc(8'hF8, 8'h01, 8'h01);
    $display("dip test done");
  endtask
  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #500000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    nrst = 1'b0;
    {main_low, sup_low, line_cycle} = 3'h0;
    {sup_smp, bat_smp, line_level} = 24'h80C0FF;
    cyc(2);
    nrst = 1'b1;
    t_reset();
    t_switch();
    t_adc();
    t_comp();
    t_dip();
    end_of_test();
  end
endmodule
`default_nettype wire
